// ===== design/opaddr_pkg.sv
// Package with encodings and constants for operand address generation
package opaddr_pkg;
    // ------------------------------------------------------------
    // Widths and register numbers
    // ------------------------------------------------------------
    localparam int          WORD_W      = 16;
    localparam int          REG_W       = 4;
    localparam int          NUM_REGS    = 16;
    localparam logic [3:0]  REG_PC      = 4'h0;
    localparam logic [3:0]  REG_FLAGS   = 4'h2;
    localparam logic [15:0] PC_STEP     = 16'h0002;
    localparam logic [15:0] ZERO_WORD   = 16'h0000;
    localparam logic [15:0] BYTE_MASK   = 16'h00FF;
    localparam logic [15:0] RESET_PC    = 16'h0000;

    // ------------------------------------------------------------
    // Mode encodings and flag positions
    // ------------------------------------------------------------
    localparam logic [1:0]  SRC_REGISTER = 2'h0;
    localparam logic [1:0]  SRC_INDEXED  = 2'h1;
    localparam logic        DST_REGISTER = 1'h0;
    localparam logic        DST_INDEXED  = 1'h1;
    localparam int          FLAG_C      = 0;
    localparam int          FLAG_Z      = 1;
    localparam int          FLAG_N      = 2;
    localparam int          BYTE_MSB    = 7;
    localparam int          WORD_MSB    = 15;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SRC_EXT = 3'b001,
        ST_DST_EXT = 3'b010,
        ST_ISSUE   = 3'b011
    } seq_state_t;
endpackage : opaddr_pkg

// ===== design/ea_adder.sv
// Effective address adder with base selection
module ea_adder
    import opaddr_pkg::*;
(
    // Base selection
    input  wire logic [3:0]  baseSel,
    input  wire logic [15:0] baseValue,
    input  wire logic [15:0] pcValue,
    // Offset and result
    input  wire logic [15:0] offset,
    output logic      [15:0] effAddr
);
    logic [15:0] base;

    // Base is PC for symbolic, zero on the flag register for absolute
    always_comb
    begin
        if (baseSel == REG_PC)
            base = pcValue;
        else if (baseSel == REG_FLAGS)
            base = ZERO_WORD;
        else
            base = baseValue;
        // base plus offset, wraps modulo 64K
        effAddr = base + offset;
    end
endmodule : ea_adder

// ===== design/operand_address_generation.sv
// Operand address generation: extension fetch, effective addresses, register write-back
module operand_address_generation
    import opaddr_pkg::*;
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst,
    // Instruction request
    input  wire logic                     instrValid,
    output logic                          instrReady,
    input  wire logic [1:0]               sourceModeField,
    input  wire logic                     dstMode,
    input  wire logic [3:0]               srcReg,
    input  wire logic [3:0]               dstReg,
    input  wire logic                     byteOp,
    // Memory word fetch port
    output logic                          fetchReq,
    output logic      [15:0]              fetchAddr,
    input  wire logic                     fetchAck,
    input  wire logic [15:0]              fetchData,
    // Operand addresses to the execution stage
    output logic                          opValid,
    output logic      [15:0]              srcAddr,
    output logic                          srcIsMem,
    output logic      [15:0]              dstAddr,
    output logic                          dstIsMem,
    output logic      [15:0]              srcRegValue,
    output logic      [15:0]              pcValue,
    // Register write-back from execution
    input  wire logic                     wbValid,
    input  wire logic [3:0]               wbReg,
    input  wire logic [15:0]              wbData,
    input  wire logic                     wbByte,
    input  wire logic                     wbCarry,
    output logic      [15:0]              flagValue
);
    import opaddr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    seq_state_t        state_ff;
    seq_state_t        nxt_state;
    logic [15:0]       regFile_ff [NUM_REGS];
    logic [15:0]       pc_ff;
    logic [15:0]       srcOff_ff;
    logic [15:0]       dstOff_ff;
    logic [1:0]        srcMode_ff;
    logic              dstMode_ff;
    logic [3:0]        srcReg_ff;
    logic [3:0]        dstReg_ff;
    logic              srcIdx;
    logic              dstIdx;
    logic [15:0]       srcEa;
    logic [15:0]       dstEa;
    logic [15:0]       wbStored;
    logic              flagsN;
    logic              flagsZ;

    // Program counter value seen by a symbolic operand is the extension word address
    logic [15:0]       srcPcBase_ff;
    logic [15:0]       dstPcBase_ff;

    assign srcIdx = (srcMode_ff == SRC_INDEXED);
    assign dstIdx = (dstMode_ff == DST_INDEXED);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Extension words come strictly one per indexed-style operand, source first
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (instrValid)
                begin
                    if (sourceModeField == SRC_INDEXED)
                        nxt_state = ST_SRC_EXT;
                    else if (dstMode == DST_INDEXED)
                        nxt_state = ST_DST_EXT;
                    else
                        nxt_state = ST_ISSUE;
                end
            end
            ST_SRC_EXT:
            begin
                if (fetchAck)
                    nxt_state = dstIdx ? ST_DST_EXT : ST_ISSUE;
            end
            ST_DST_EXT:
            begin
                if (fetchAck)
                    nxt_state = ST_ISSUE;
            end
            ST_ISSUE:
                nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Latch the decoded instruction fields when taken
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            srcMode_ff <= SRC_REGISTER;
            dstMode_ff <= DST_REGISTER;
            srcReg_ff  <= REG_PC;
            dstReg_ff  <= REG_PC;
        end
        else if (state_ff == ST_IDLE && instrValid)
        begin
            srcMode_ff <= sourceModeField;
            dstMode_ff <= dstMode;
            srcReg_ff  <= srcReg;
            dstReg_ff  <= dstReg;
        end
    end

    // ------------------------------------------------------------
    // Extension word fetch and program counter
    // ------------------------------------------------------------
    assign instrReady = (state_ff == ST_IDLE);
    assign fetchReq   = (state_ff == ST_SRC_EXT) || (state_ff == ST_DST_EXT);
    // offset is the word at the PC
    assign fetchAddr  = pc_ff;

    // PC points past the opcode when the instruction is presented
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pc_ff <= RESET_PC;
        else if (fetchReq && fetchAck)
            pc_ff <= pc_ff + PC_STEP;
        else if (wbValid && wbReg == REG_PC)
            pc_ff <= wbData;
    end

    // Capture offsets and the PC each was fetched at
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            srcOff_ff    <= ZERO_WORD;
            dstOff_ff    <= ZERO_WORD;
            srcPcBase_ff <= ZERO_WORD;
            dstPcBase_ff <= ZERO_WORD;
        end
        else if (fetchAck && state_ff == ST_SRC_EXT)
        begin
            srcOff_ff    <= fetchData;
            srcPcBase_ff <= pc_ff;
        end
        else if (fetchAck && state_ff == ST_DST_EXT)
        begin
            dstOff_ff    <= fetchData;
            dstPcBase_ff <= pc_ff;
        end
    end

    // ------------------------------------------------------------
    // Effective addresses
    // ------------------------------------------------------------
    // symbolic uses PC base
    ea_adder srcAdder (
        .baseSel   (srcReg_ff),
        .baseValue (regFile_ff[srcReg_ff]),
        .pcValue   (srcPcBase_ff),
        .offset    (srcOff_ff),
        .effAddr   (srcEa)
    );

    ea_adder dstAdder (
        .baseSel   (dstReg_ff),
        .baseValue (regFile_ff[dstReg_ff]),
        .pcValue   (dstPcBase_ff),
        .offset    (dstOff_ff),
        .effAddr   (dstEa)
    );

    // Registered operand descriptor, one cycle pulse of opValid
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            opValid     <= 1'b0;
            srcAddr     <= ZERO_WORD;
            dstAddr     <= ZERO_WORD;
            srcIsMem    <= 1'b0;
            dstIsMem    <= 1'b0;
            srcRegValue <= ZERO_WORD;
            pcValue     <= RESET_PC;
        end
        else
        begin
            opValid     <= (state_ff == ST_ISSUE);
            srcAddr     <= srcIdx ? srcEa : ZERO_WORD;
            dstAddr     <= dstIdx ? dstEa : ZERO_WORD;
            srcIsMem    <= srcIdx;
            dstIsMem    <= dstIdx;
            // operand read straight from the register
            srcRegValue <= (srcReg_ff == REG_PC) ? pc_ff : regFile_ff[srcReg_ff];
            pcValue     <= pc_ff;
        end
    end

    // ------------------------------------------------------------
    // Register write-back and flags
    // ------------------------------------------------------------
    // high byte cleared
    assign wbStored = wbByte ? (wbData & BYTE_MASK) : wbData;
    assign flagsN   = wbByte ? wbData[BYTE_MSB] : wbData[WORD_MSB];
    assign flagsZ   = wbByte ? ((wbData & BYTE_MASK) == ZERO_WORD) : (wbData == ZERO_WORD);

    // address generation never writes its bases
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regFile_ff[i] <= ZERO_WORD;
        end
        else if (wbValid && wbReg != REG_PC)
        begin
            if (wbReg == REG_FLAGS)
                regFile_ff[REG_FLAGS] <= wbStored;
            else
            begin
                regFile_ff[wbReg] <= wbStored;
                regFile_ff[REG_FLAGS][FLAG_N] <= flagsN;
                regFile_ff[REG_FLAGS][FLAG_Z] <= flagsZ;
                regFile_ff[REG_FLAGS][FLAG_C] <= wbCarry;
            end
        end
    end

    assign flagValue = regFile_ff[REG_FLAGS];
endmodule : operand_address_generation

// ===== verification/opaddr_mem.sv
// Memory partner model answering extension word fetches
module opaddr_mem
(
    // Fetch port
    input  wire logic        mclk,
    input  wire logic        fetchReq,
    input  wire logic [15:0] fetchAddr,
    output logic             fetchAck,
    output logic      [15:0] fetchData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [logic [15:0]];
    int          lag = 0;
    int          waitCnt = 0;
    logic [15:0] junk = 16'h0000;
    initial fetchAck = 1'b0;
    // Answer after lag cycles; the data lines churn outside the answer cycle
    always @(posedge mclk)
    begin
        junk <= junk + 16'h1357;
        if (fetchReq && !fetchAck && waitCnt >= lag)
        begin
            waitCnt <= 0;
            fetchAck <= 1'b1;
            fetchData <= mem.exists(fetchAddr) ? mem[fetchAddr] : ~fetchAddr;
        end
        else
        begin
            // Ack is a single-cycle pulse; the data lines show junk outside it
            fetchAck <= 1'b0;
            fetchData <= ~junk;
            if (fetchReq && !fetchAck)
                waitCnt <= waitCnt + 1;
        end
    end
endmodule : opaddr_mem

// ===== verification/operand_address_generation_checker.sv
// Checker for fetch order, result timing and flag updates
module operand_address_generation_checker
    import opaddr_pkg::*;
(
    // Clock, reset and request
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        instrValid,
    input wire logic        instrReady,
    input wire logic [1:0]  sourceModeField,
    input wire logic        dstMode,
    // Fetch and result
    input wire logic        fetchReq,
    input wire logic [15:0] fetchAddr,
    input wire logic        fetchAck,
    input wire logic        opValid,
    input wire logic        srcIsMem,
    input wire logic        dstIsMem,
    // Write-back and flags
    input wire logic        wbValid,
    input wire logic [3:0]  wbReg,
    input wire logic [15:0] wbData,
    input wire logic        wbByte,
    input wire logic        wbCarry,
    input wire logic [15:0] flagValue
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic take;
    logic regTake;
    logic extTake;
    logic gpr;
    logic srcMem_ff;
    logic dstMem_ff;
    assign take = instrValid && instrReady;
    assign regTake = take && sourceModeField == SRC_REGISTER && !dstMode;
    assign extTake = take && sourceModeField == SRC_INDEXED && dstMode;
    assign gpr = wbValid && wbReg != REG_PC && wbReg != REG_FLAGS;
    // Modes kept until the result shows, since the inputs may move on
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            {srcMem_ff, dstMem_ff} <= 2'h0;
        else if (take)
            {srcMem_ff, dstMem_ff} <= {sourceModeField == SRC_INDEXED, dstMode};
    end
    property p_reg_answer; regTake |-> ##2 opValid; endproperty
    a_reg_answer: assert property (p_reg_answer) else $error("late result");
    property p_reg_nofetch; regTake |=> !fetchReq [*2]; endproperty
    a_reg_nofetch: assert property (p_reg_nofetch) else $error("stray fetch");
    property p_ext_fetch; extTake |=> fetchReq; endproperty
    a_ext_fetch: assert property (p_ext_fetch) else $error("no offset fetch");
    property p_fetch_hold; fetchReq && !fetchAck |=> fetchReq && $stable(fetchAddr); endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped");
    property p_fetch_step; fetchReq && fetchAck ##1 fetchReq |-> fetchAddr == $past(fetchAddr) + PC_STEP; endproperty
    a_fetch_step: assert property (p_fetch_step) else $error("bad step");
    property p_busy; fetchReq |-> !instrReady; endproperty
    a_busy: assert property (p_busy) else $error("ready in fetch");
    property p_kind; opValid |-> srcIsMem == srcMem_ff && dstIsMem == dstMem_ff; endproperty
    a_kind: assert property (p_kind) else $error("wrong operand kind");
    property p_byte_flags; gpr && wbByte |=> flagValue[2:0] ==
        {$past(wbData[7]), $past(wbData[7:0]) == 8'h00, $past(wbCarry)}; endproperty
    a_byte_flags: assert property (p_byte_flags) else $error("byte flags");
    c_ext: cover property (extTake);
    c_slow: cover property (fetchReq && !fetchAck [*2]);
    c_byte: cover property (gpr && wbByte);
endmodule : operand_address_generation_checker
bind operand_address_generation operand_address_generation_checker chk_u (.*);

// ===== verification/operand_address_generation_bench.sv
// Bench for operand address generation with a memory partner
module operand_address_generation_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import opaddr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        instrValid = 1'b0;
    logic [1:0]  sourceModeField = 2'h0;
    logic        dstMode = 1'b0;
    logic [3:0]  srcReg = 4'h0;
    logic [3:0]  dstReg = 4'h0;
    logic        byteOp = 1'b0;
    logic        wbValid = 1'b0;
    logic [3:0]  wbReg = 4'h0;
    logic [15:0] wbData = 16'h0000;
    logic        wbByte = 1'b0;
    logic        wbCarry = 1'b0;
    logic        instrReady, fetchReq, fetchAck, opValid, srcIsMem, dstIsMem;
    logic [15:0] fetchAddr, fetchData, srcAddr, dstAddr, srcRegValue, pcValue, flagValue;
    logic [66:0] expQ [$];
    logic [66:0] e;
    logic [66:0] note;
    logic [31:0] seed = 32'hEBB2;
    logic [15:0] base, pc, off, off2, pe;
    logic [1:0]  k;
    int          nFail = 0;
    int          checkCount = 0;
    int          cyc = 0;
    operand_address_generation dut_u (.*);
    opaddr_mem mem_u (.mclk(mclk), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
        .fetchAck(fetchAck), .fetchData(fetchData));
    initial
    begin
        forever #20 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr
    task automatic close_out();
        $display("checks %0d failures %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
        checkCount++;
        if (got !== want)
        begin
            nFail++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
        end
    endtask : check
    task automatic wb(input logic [3:0] r, input logic [15:0] d, input logic b, input logic c);
        @(posedge mclk);
        wbValid <= 1'b1;
        {wbReg, wbData, wbByte, wbCarry} <= {r, d, b, c};
        @(posedge mclk);
        wbValid <= 1'b0;
    endtask : wb
    // Note the expectation, hold the request until taken, then await the result
    task automatic instr(input logic [3:0] s, input logic [3:0] d, input logic [66:0] x);
        expQ.push_back(x);
        seed = lfsr(seed);
        @(posedge mclk);
        instrValid <= 1'b1;
        {sourceModeField, dstMode, srcReg, dstReg, byteOp} <= {1'b0, x[65:64], s, d, seed[0]};
        do @(posedge mclk); while (instrReady !== 1'b1);
        instrValid <= 1'b0;
        while (expQ.size() != 0) @(posedge mclk);
    endtask : instr
    // Hang guard, well above the hundred or so cycles the run needs
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            nFail++;
            close_out();
        end
    end
    // Each result is matched against the oldest note, mid-cycle while the outputs are settled
    always @(negedge mclk)
    begin
        if (opValid === 1'b1)
        begin
            if (expQ.size() == 0)
                check(16'h0001, 16'h0000, "unexpected result");
            else
            begin
                note = expQ.pop_front();
                check({14'h0, srcIsMem, dstIsMem}, {14'h0, note[65:64]}, "kind");
                check(srcAddr, note[63:48], "src addr");
                check(dstAddr, note[47:32], "dst addr");
                check(pcValue, note[31:16], "pc");
                if (note[66])
                    check(srcRegValue, note[15:0], "reg");
            end
        end
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        wb(4'h5, 16'h1080, 1'b0, 1'b0);
        wb(4'h6, 16'h108C, 1'b0, 1'b0);
        wb(4'h0, 16'hFF14, 1'b0, 1'b0);
        mem_u.mem[16'hFF14] = 16'h0002;
        mem_u.mem[16'hFF16] = 16'h0006;
        instr(4'h5, 4'h6, {3'h7, 16'h1082, 16'h1092, 16'hFF18, 16'h1080});
        instr(4'h5, 4'h6, {3'h4, 16'h0000, 16'h0000, 16'hFF18, 16'h1080});
        // Slow memory on the symbolic case, offsets relative to each word
        mem_u.lag = 2;
        wb(4'h0, 16'hFF14, 1'b0, 1'b0);
        mem_u.mem[16'hFF14] = 16'hF102;
        mem_u.mem[16'hFF16] = 16'h11FE;
        instr(4'h0, 4'h0, {3'h3, 16'hF016, 16'h1114, 16'hFF18, 16'h0000});
        mem_u.lag = 0;
        wb(4'h0, 16'hFF14, 1'b0, 1'b0);
        mem_u.mem[16'hFF14] = 16'hF016;
        mem_u.mem[16'hFF16] = 16'h1114;
        instr(4'h2, 4'h2, {3'h3, 16'hF016, 16'h1114, 16'hFF18, 16'h0000});
        // Random bases and offsets over the mode pairs with at least one indexed operand
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            base = seed[15:0];
            pc = {seed[31:17], 1'b0};
            seed = lfsr(seed);
            {off, off2} = seed;
            k = 2'(i % 3 + 1);
            wb(4'h9, base, 1'b0, 1'b0);
            wb(4'h0, pc, 1'b0, 1'b0);
            mem_u.mem[pc] = off;
            mem_u.mem[pc + 16'h0002] = off2;
            pe = pc + (k[1] ? 16'h0002 : 16'h0000) + (k[0] ? 16'h0002 : 16'h0000);
            e[63:48] = k[1] ? base + off : 16'h0000;
            e[47:32] = k[0] ? base + (k[1] ? off2 : off) : 16'h0000;
            instr(4'h9, 4'h9, {1'b1, k, e[63:32], pe, base});
        end
        wb(4'h7, 16'hAB80, 1'b1, 1'b1);
        @(negedge mclk);
        check({13'h0, flagValue[2:0]}, 16'h0005, "byte flags");
        instr(4'h7, 4'h7, {3'h4, 16'h0000, 16'h0000, pe, 16'h0080});
        wb(4'h8, 16'h3400, 1'b1, 1'b0);
        @(negedge mclk);
        check({13'h0, flagValue[2:0]}, 16'h0002, "zero flag");
        close_out();
    end
endmodule : operand_address_generation_bench
